/* File: rtl/enc_in_pkg.sv */
// Purpose: constants for the incremental position input decoder
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: the block counts four per line in quadrature, pulse/direction and up/down modes; the spare mode counts nothing
// Overview of operation
// RULE_01: count every edge of both tracks, four counts per encoder line; the code counts neither edge when both tracks change in one cycle.
// RULE_02: with index, counts between index pulses should equal counts per revolution.
// RULE_03: quadrature mode decodes two tracks 90 degrees apart plus optional index.
// RULE_04: pulse/direction mode: one input steps, the other selects direction.
// RULE_05: up/down mode: each input counts one way; sender idles the other.
// RULE_06: ignore-counter option freezes the count as if encoder stood still.
// RULE_07: ignore-index option stops the index from realigning the count.
// RULE_08: evaluated index realigns count to revolution boundary, possibly jumping.
// RULE_09: fault input uses index pin, only without index track; raises error.
// RULE_10: fault input polarity selectable, low-active or high-active.
// RULE_11: fault detection has its own enable control.
// RULE_12: quadrature counts up when track A leads, down when track B leads.
package enc_in_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] LINES_OFFS = 8'h04;
    localparam logic [7:0] POS_OFFS = 8'h08;
    localparam logic [7:0] STAT_OFFS = 8'h0C;
    localparam logic [7:0] MASK_OFFS = 8'h10;
    localparam logic [7:0] EVT_OFFS = 8'h14;
    localparam logic [7:0] ERRC_OFFS = 8'h18;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_IGN_CNT = 2;
    localparam int CTRL_IGN_IDX = 3;
    localparam int CTRL_IDX_EN = 4;
    localparam int CTRL_FLT_EN = 5;
    localparam int CTRL_FLT_HIGH = 6;
    localparam int CTRL_CLR_POS = 7;
    // event bits
    localparam int EV_INDEX = 0;
    localparam int EV_JUMP = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_WIDTH = 3;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] LINES_RST = 32'h0000_0400;
    localparam logic [2:0] MASK_RST = 3'h0;
    // encoder fault code 08-7, packed as group and number
    localparam logic [15:0] FAULT_CODE = 16'h0807;
    // edge quadrupling factor
    localparam int EDGES_PER_LINE = 4;
    typedef enum logic [1:0] {
        MODE_QUAD,
        MODE_PULSE_DIR,
        MODE_UP_DOWN,
        MODE_SPARE
    } dec_mode_t;
endpackage : enc_in_pkg

/* File: rtl/pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: one clock, asynchronous active-low reset
// Notes: a change is taken once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [WIDTH-1:0] pin_in, // raw pins
    output logic [WIDTH-1:0] pin_out // filtered level
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // stage one only feeds stage two, to keep metastability contained
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // output follows only when the two settled stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    pin_out[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync

/* File: rtl/enc_in.sv */
// Purpose: incremental encoder / master frequency position input
// Assumes: tracks and index arrive asynchronously on pins
// Notes: position is a signed 32-bit count, four per line
`timescale 1ns/1ns
module enc_in
    import enc_in_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk_sys, // 20 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    input wire logic wb_we_i, // write enable
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    input wire logic track_a, // track A / pulse / up input
    input wire logic track_b, // track B / direction / down input
    input wire logic index_pin, // index or fault input
    output logic irq, // level interrupt
    output logic enc_fault // fault present, drives error 08-7
);
    logic [2:0] pins;
    logic a_s, b_s, n_s;
    logic a_d, b_d, n_d;
    logic [7:0] ctrl_reg;
    logic [31:0] lines_reg;
    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] rev_reg;
    logic [POS_W-1:0] rev_cnt_reg;
    logic [EV_WIDTH-1:0] stat_reg;
    logic [EV_WIDTH-1:0] mask_reg;
    logic [31:0] idx_gap_reg;
    logic wb_hit;
    logic wb_wr;
    logic [POS_W-1:0] half_rev;
    logic wr_ctrl, wr_lines, wr_stat, wr_mask;
    logic step_up, step_dn;
    logic idx_rise, idx_eval;
    logic flt_level, flt_prev_reg, flt_rise;
    logic [POS_W-1:0] pos_next;
    logic [POS_W-1:0] rem_next;
    logic idx_jump;
    logic [EV_WIDTH-1:0] ev_set;
    dec_mode_t mode;

    pin_sync #(.WIDTH(3)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in({index_pin, track_b, track_a}),
        .pin_out(pins)
    );
    assign a_s = pins[0];
    assign b_s = pins[1];
    assign n_s = pins[2];

    // delayed copies for edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            a_d <= 1'b0;
            b_d <= 1'b0;
            n_d <= 1'b0;
        end else begin
            a_d <= a_s;
            b_d <= b_s;
            n_d <= n_s;
        end
    end

    assign mode = dec_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);

    // step decode; in quadrature each edge of either track counts once, unless both tracks change in one cycle
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (mode)
            MODE_QUAD: begin
                // a change on one track, relative to the other's level,
                // gives direction; A leading B counts up [RULE_03] [RULE_12]
                if ((a_s != a_d) && (b_s == b_d)) begin // [RULE_01]
                    step_up = (a_s != b_s);
                    step_dn = (a_s == b_s);
                end else if ((b_s != b_d) && (a_s == a_d)) begin // [RULE_01]
                    step_up = (a_s == b_s);
                    step_dn = (a_s != b_s);
                end
            end
            MODE_PULSE_DIR: begin
                // each pulse edge is one quarter line step [RULE_04]
                if (a_s != a_d) begin
                    step_up = !b_s;
                    step_dn = b_s;
                end
            end
            MODE_UP_DOWN: begin
                // the sender keeps the other line idle; if both move in
                // one cycle they cancel [RULE_05]
                step_up = (a_s != a_d) && (b_s == b_d);
                step_dn = (b_s != b_d) && (a_s == a_d);
            end
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
        // frozen counter sees a standstill [RULE_06]
        if (ctrl_reg[CTRL_IGN_CNT]) begin
            step_up = 1'b0;
            step_dn = 1'b0;
        end
    end

    // counts per revolution are four times the line count [RULE_01]
    assign rev_reg = POS_W'(lines_reg) * POS_W'(EDGES_PER_LINE);
    // half a revolution decides which boundary is the nearest
    assign half_rev = rev_reg >> 1;

    // index only counts in quadrature with a track configured [RULE_03]
    assign idx_rise = n_s && !n_d;
    assign idx_eval = idx_rise && (mode == MODE_QUAD)
        && ctrl_reg[CTRL_IDX_EN] && !ctrl_reg[CTRL_IGN_IDX]; // [RULE_07]

    // next position and position within the revolution
    always_comb begin
        pos_next = pos_reg;
        rem_next = rev_cnt_reg;
        idx_jump = 1'b0;
        if (step_up) begin
            pos_next = pos_reg + POS_W'(1);
            rem_next = rev_cnt_reg + POS_W'(1);
        end else if (step_dn) begin
            pos_next = pos_reg - POS_W'(1);
            rem_next = rev_cnt_reg - POS_W'(1);
        end
        if (idx_eval) begin
            // snap to the nearest revolution boundary; any offset but a
            // whole turn shows missed increments [RULE_02] [RULE_08]
            if (rem_next != '0 && rem_next != rev_reg
                && rem_next != -rev_reg) begin
                idx_jump = 1'b1;
            end
            // a step in the index cycle is kept, as the snap uses rem_next
            if ($signed(rem_next) > $signed(half_rev)) begin
                pos_next = pos_next - rem_next + rev_reg;
            end else if ($signed(rem_next) < -$signed(half_rev)) begin
                pos_next = pos_next - rem_next - rev_reg;
            end else begin
                pos_next = pos_next - rem_next;
            end
            rem_next = '0;
        end
    end

    // position counter; software may zero it through the control word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= '0;
            rev_cnt_reg <= '0;
        end else if (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_CLR_POS]) begin
            pos_reg <= '0;
            rev_cnt_reg <= '0;
        end else begin
            pos_reg <= pos_next;
            rev_cnt_reg <= rem_next;
        end
    end

    // counts seen between the last two index pulses, for diagnosis
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx_gap_reg <= '0;
        end else if (idx_eval) begin
            idx_gap_reg <= 32'(rev_cnt_reg); // [RULE_02]
        end
    end

    // fault input shares the index pin and is ignored while an index
    // track is configured [RULE_09] [RULE_11]
    assign flt_level = ctrl_reg[CTRL_FLT_EN] && !ctrl_reg[CTRL_IDX_EN]
        && (ctrl_reg[CTRL_FLT_HIGH] ? n_s : !n_s); // [RULE_10]
    assign flt_rise = flt_level && !flt_prev_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flt_prev_reg <= 1'b0;
            enc_fault <= 1'b0;
        end else begin
            flt_prev_reg <= flt_level;
            enc_fault <= flt_level; // [RULE_09]
        end
    end

    // bus decode; single-cycle ack, dropped the cycle after
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land at the edge where the master sees ack, while it still
    // holds address and data
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wr_ctrl = wb_wr && (wb_adr_i == CTRL_OFFS);
    assign wr_lines = wb_wr && (wb_adr_i == LINES_OFFS);
    assign wr_stat = wb_wr && (wb_adr_i == STAT_OFFS);
    assign wr_mask = wb_wr && (wb_adr_i == MASK_OFFS);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    // configuration registers; clear-position bit is self-clearing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
            lines_reg <= LINES_RST;
            mask_reg <= MASK_RST;
        end else begin
            if (wr_ctrl && wb_sel_i[0]) begin
                ctrl_reg <= wb_dat_i[7:0] & 8'h7F;
            end
            if (wr_lines) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) begin
                        lines_reg[8*i +: 8] <= wb_dat_i[8*i +: 8];
                    end
                end
            end
            if (wr_mask && wb_sel_i[0]) begin
                mask_reg <= wb_dat_i[EV_WIDTH-1:0];
            end
        end
    end

    // sticky events; a new event beats a write-one clear
    assign ev_set[EV_INDEX] = idx_eval;
    assign ev_set[EV_JUMP] = idx_jump; // [RULE_08]
    assign ev_set[EV_FAULT] = flt_rise; // [RULE_09]

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= '0;
        end else if (wr_stat && wb_sel_i[0]) begin
            stat_reg <= (stat_reg & ~wb_dat_i[EV_WIDTH-1:0]) | ev_set;
        end else begin
            stat_reg <= stat_reg | ev_set;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // read mux registered with the ack; unmapped reads return zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= '0;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFFS: wb_dat_o <= {24'h000000, ctrl_reg};
                LINES_OFFS: wb_dat_o <= lines_reg;
                POS_OFFS: wb_dat_o <= 32'(pos_reg);
                STAT_OFFS: wb_dat_o <= {29'h0, stat_reg};
                MASK_OFFS: wb_dat_o <= {29'h0, mask_reg};
                EVT_OFFS: wb_dat_o <= idx_gap_reg;
                ERRC_OFFS: wb_dat_o <= {15'h0, enc_fault, FAULT_CODE};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : enc_in

/* File: sim/enc_in_monitor.sv */
// Purpose: port checker for enc_in
// Assumes: one clock domain, pins held at least four cycles
// Notes: quiet counts cycles free of pin edges and bus writes
`timescale 1ns/1ns
module enc_in_monitor
    import enc_in_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset, low
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_we_i, // write
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic track_a, // track A
    input wire logic track_b, // track B
    input wire logic index_pin, // index
    input wire logic irq, // interrupt
    input wire logic enc_fault // fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [2:0] pins, pins_q;
    logic [3:0] quiet;
    logic rd;
    assign pins = {track_a, track_b, index_pin};
    assign rd = wb_ack_o && !wb_we_i;
    // sync plus logic settles in ~6 cycles, so ten quiet cycles are frozen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins_q <= 3'h0;
            quiet <= 4'h0;
        end else begin
            pins_q <= pins;
            if (pins != pins_q || (wb_ack_o && wb_we_i))
                quiet <= 4'h0;
            else if (quiet != 4'hF)
                quiet <= quiet + 4'h1;
        end
    end
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
    ack_pulse_a: assert property (req_s |=> ack_pulse_s)
        else $error("ack missing or longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    fault_code_a: assert property (
        rd && wb_adr_i == ERRC_OFFS |-> wb_dat_o[15:0] == FAULT_CODE)
        else $error("wrong fault code");
    clear_bit_a: assert property (
        rd && wb_adr_i == CTRL_OFFS |-> !wb_dat_o[CTRL_CLR_POS])
        else $error("clear bit reads back set");
    unmapped_zero_a: assert property (
        rd && wb_adr_i >= 8'h1C |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    irq_quiet_a: assert property (quiet >= 4'hA |-> $stable(irq))
        else $error("irq moved with no cause");
    fault_quiet_a: assert property (
        quiet >= 4'hA |-> $stable(enc_fault))
        else $error("fault moved with no cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
        else $error("irq fell without a write");
endmodule : enc_in_monitor
bind enc_in enc_in_monitor u_mon (.clk_sys, .rst_n, .wb_adr_i, .wb_dat_o,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .track_a, .track_b,
    .index_pin, .irq, .enc_fault);

/* File: sim/enc_model.sv */
// Purpose: encoder or master drive on the far side of the pins
// Assumes: tasks are entered just after a rising clock edge
// Notes: edges four clocks apart, inside the decoder's limit
`timescale 1ns/1ns
module enc_model (
    input wire logic clk_sys, // clock
    output logic track_a, // A / pulse / up
    output logic track_b, // B / direction / down
    output logic index_pin // index or fault level
);
    // lines rest low until the bench moves them
    initial begin
        track_a = 1'h0;
        track_b = 1'h0;
        index_pin = 1'h0;
    end
    // one edge per pass; direction settles before the first pulse
    task automatic move(input logic [1:0] md, input int n, input logic up);
        if (md == 2'h1)
            track_b <= !up;
        repeat (4) @(posedge clk_sys);
        repeat (n) begin
            if (md == 2'h0 && (track_a == track_b) == up)
                track_a <= !track_a;
            else if (md == 2'h0)
                track_b <= !track_b;
            else if (md == 2'h1 || up)
                track_a <= !track_a;
            else
                track_b <= !track_b;
            repeat (4) @(posedge clk_sys);
        end
    endtask : move
    // index pulse while the tracks stand still
    task automatic pulse_index();
        index_pin <= 1'h1;
        repeat (4) @(posedge clk_sys);
        index_pin <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask : pulse_index
    task automatic set_pin(input logic v);
        index_pin <= v;
    endtask : set_pin
endmodule : enc_model

/* File: sim/enc_in_test.sv */
// Purpose: self-checking bench for enc_in
// Assumes: a pin edge reaches the outputs within ten cycles
// Notes: plain moves come from a table, the rest by hand
`timescale 1ns/1ns
module enc_in_test;
    import enc_in_pkg::*;
    typedef struct {logic [7:0] ctrl; int n; logic up;
        logic [31:0] exp;} row_t;
    logic clk_sys = 1'h0, rst_n = 1'h0, wb_we_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic track_a, track_b, index_pin, irq, enc_fault;
    logic [7:0] fc[4] = '{8'h20, 8'h00, 8'h20, 8'h30};
    logic fe[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
    int errors = 0, checked = 0;
    // ctrl[1:0] is the mode; exp is the count after a clear
    row_t rw[8] = '{'{8'h00, 8, 1'h1, 32'h8}, '{8'h00, 5, 1'h0, 32'hFFFFFFFB},
        '{8'h01, 6, 1'h1, 32'h6}, '{8'h01, 3, 1'h0, 32'hFFFFFFFD},
        '{8'h02, 7, 1'h1, 32'h7}, '{8'h02, 4, 1'h0, 32'hFFFFFFFC},
        '{8'h04, 8, 1'h1, 32'h0}, '{8'h03, 4, 1'h1, 32'h0}};
    enc_in uut (.clk_sys, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i(4'hF), .wb_cyc_i, .wb_stb_i, .wb_ack_o, .track_a, .track_b,
        .index_pin, .irq, .enc_fault);
    enc_model enc (.clk_sys, .track_a, .track_b, .index_pin);
    always #25 clk_sys = ~clk_sys;
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t word %h want %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t bit %b want %b", $time, got, exp);
        end
    endtask : chk_b
    // one classic cycle; waits for ack, then checks that ack drops again
    task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_sys);
        chk_b(wb_ack_o, 1'h0);
    endtask : bus
    task automatic settle();
        repeat (10) @(posedge clk_sys);
    endtask : settle
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // the whole run needs about 650 cycles
    initial begin
        repeat (8000) @(posedge clk_sys);
        errors++;
        $display("MISMATCH %0t watchdog", $time);
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        foreach (rw[i]) begin
            bus(CTRL_OFFS, 1'h1, {24'h0, rw[i].ctrl | 8'h80});
            enc.move(rw[i].ctrl[1:0], rw[i].n, rw[i].up);
            settle();
            bus(POS_OFFS, 1'h0, 32'h0);
            chk_w(q, rw[i].exp);
        end
        $display("test table done");
        // four lines make a sixteen-count revolution
        bus(LINES_OFFS, 1'h1, 32'h4);
        bus(CTRL_OFFS, 1'h1, 32'h90);
        bus(STAT_OFFS, 1'h1, 32'h7);
        enc.move(2'h0, 16, 1'h1);
        enc.pulse_index();
        settle();
        bus(POS_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h10);
        bus(STAT_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h1);
        bus(STAT_OFFS, 1'h1, 32'h7);
        enc.move(2'h0, 2, 1'h1);
        enc.pulse_index();
        settle();
        bus(POS_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h10);
        bus(STAT_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h3);
        bus(EVT_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h2);
        bus(CTRL_OFFS, 1'h1, 32'h18);
        enc.move(2'h0, 2, 1'h1);
        enc.pulse_index();
        settle();
        bus(POS_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h12);
        $display("test index done");
        bus(CTRL_OFFS, 1'h1, 32'h60);
        bus(MASK_OFFS, 1'h1, 32'h4);
        bus(STAT_OFFS, 1'h1, 32'h7);
        chk_b(irq, 1'h0);
        enc.set_pin(1'h1);
        settle();
        chk_b(enc_fault, 1'h1);
        chk_b(irq, 1'h1);
        bus(ERRC_OFFS, 1'h0, 32'h0);
        chk_w(q, {15'h0, 1'h1, 16'h0807});
        bus(MASK_OFFS, 1'h1, 32'h0);
        chk_b(irq, 1'h0);
        bus(MASK_OFFS, 1'h1, 32'h4);
        chk_b(irq, 1'h1);
        bus(STAT_OFFS, 1'h1, 32'h4);
        chk_b(irq, 1'h0);
        bus(CTRL_OFFS, 1'h1, 32'h20);
        settle();
        chk_b(enc_fault, 1'h0);
        enc.set_pin(1'h0);
        foreach (fc[i]) begin
            bus(CTRL_OFFS, 1'h1, {24'h0, fc[i]});
            settle();
            chk_b(enc_fault, fe[i]);
        end
        bus(8'h1C, 1'h0, 32'h0);
        chk_w(q, 32'h0);
        $display("test fault done");
        rst_n <= 1'h0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        bus(CTRL_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h0);
        bus(LINES_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h400);
        bus(MASK_OFFS, 1'h0, 32'h0);
        chk_w(q, 32'h0);
        chk_b(irq, 1'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule : enc_in_test
